// *** src/fault_reset_role_config.sv ***
// card configuration and fault recovery reset control
module fault_reset_role_config
  import fault_reset_role_pkg::*;
#(
  parameter int RST_CYC = SYSRST_CYC
)(
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_ce,
  input  wire logic        i_base_addr_sel_hi,
  input  wire logic        i_base_addr_sel_lo,
  input  wire logic        i_fault_reset_option,
  input  wire logic        i_config_source_sel,
  input  wire logic        i_primary_role_sel,
  input  wire logic        i_recompile_enable_switch,
  input  wire logic        i_slot1,
  input  wire logic        i_fault,
  input  wire logic        i_sysreset_seen,
  input  wire logic        i_peers_ready,
  output logic             o_compat_mode,
  output logic             o_primary,
  output logic             o_recompile_en,
  output logic [23:0]      o_a24_base,
  output logic [15:0]      o_a16_base,
  output logic             o_sysreset_out,
  output logic             o_sysreset_oe,
  output logic             o_to_program,
  output logic             o_in_fault
);
  import fault_reset_role_pkg::*;

  initial begin
    if (RST_CYC < 1 || RST_CYC >= (1 << SYSRST_CNT_W))
      $error("RST_CYC out of range");
  end

  //////////////////////////////////////////////////////////////////////
  cfg_bus_if cfg ();

  switch_decoder u_dec (
    .i_ref_clk                 (i_ref_clk),
    .i_resetn                  (i_resetn),
    .i_ce                      (i_ce),
    .i_base_addr_sel_hi        (i_base_addr_sel_hi),
    .i_base_addr_sel_lo        (i_base_addr_sel_lo),
    .i_fault_reset_option      (i_fault_reset_option),
    .i_config_source_sel       (i_config_source_sel),
    .i_primary_role_sel        (i_primary_role_sel),
    .i_recompile_enable_switch (i_recompile_enable_switch),
    .i_slot1                   (i_slot1),
    .cfg                       (cfg)
  );

  //////////////////////////////////////////////////////////////////////
  fault_state_t            state_reg;
  fault_state_t            state_next;
  logic [SYSRST_CNT_W-1:0] cnt_reg;
  logic                    may_drive;
  logic                    wait_rst;
  logic                    cnt_done;

  // only slot 1 may drive; compat forces the option On for it
  assign may_drive = cfg.fault_reset_option & cfg.primary
                   & cfg.slot1;
  // option On and not the driver: wait for the backplane reset
  assign wait_rst  = cfg.fault_reset_option & ~may_drive;
  assign cnt_done  = (cnt_reg == SYSRST_CNT_W'(RST_CYC - 1));

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (i_fault) state_next = ST_FAULT;
      end
      ST_FAULT: begin
        if (may_drive)
          state_next = ST_DRIVE_RST;
        else if (wait_rst)
          state_next = ST_WAIT_RST;
        else if (i_peers_ready)
          state_next = ST_RUN;
      end
      ST_DRIVE_RST: begin
        if (cnt_done) state_next = ST_RUN;
      end
      ST_WAIT_RST: begin
        if (i_sysreset_seen) state_next = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      state_reg <= ST_RUN;
      cnt_reg   <= '0;
    end else if (i_ce) begin
      state_reg <= state_next;
      cnt_reg   <= (state_reg == ST_DRIVE_RST) ? cnt_reg + 1'b1 : '0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // registered outputs; a fault recovery leaves config untouched
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_compat_mode  <= 1'b1;
      o_primary      <= 1'b0;
      o_recompile_en <= RECOMP_DEFAULT;
      o_a24_base     <= A24_BASE_0;
      o_a16_base     <= A16_BASE_0;
      o_sysreset_out <= 1'b0;
      o_sysreset_oe  <= 1'b0;
      o_to_program   <= 1'b0;
      o_in_fault     <= 1'b0;
    end else if (i_ce) begin
      o_compat_mode  <= cfg.compat_mode;
      o_primary      <= cfg.primary;
      o_recompile_en <= cfg.recompile_en;
      o_a24_base     <= cfg.a24_base;
      o_a16_base     <= cfg.a16_base;
      o_sysreset_out <= 1'b0;
      o_sysreset_oe  <= (state_next == ST_DRIVE_RST) & cfg.slot1;
      o_to_program   <= (state_reg != ST_RUN) & (state_next == ST_RUN);
      o_in_fault     <= (state_next != ST_RUN);
    end
  end
endmodule : fault_reset_role_config

// *** src/fault_reset_role_pkg.sv ***
// constants for the switch decoder and fault recovery block
package fault_reset_role_pkg;
  localparam int          A24_W          = 24;
  localparam int          A16_W          = 16;
  localparam int          SEL_W          = 2;
  // base address select: index is {hi, lo}, a switch On reads as 1
  localparam logic [1:0]  SEL_ON_ON      = 2'h3;
  localparam logic [1:0]  SEL_ON_OFF     = 2'h2;
  localparam logic [1:0]  SEL_OFF_ON     = 2'h1;
  localparam logic [1:0]  SEL_OFF_OFF    = 2'h0;
  localparam logic [23:0] A24_BASE_0     = 24'h000000;
  localparam logic [23:0] A24_BASE_1     = 24'h400000;
  localparam logic [23:0] A24_BASE_2     = 24'h800000;
  localparam logic [23:0] A24_BASE_3     = 24'hC00000;
  localparam logic [15:0] A16_BASE_0     = 16'h0000;
  localparam logic [15:0] A16_BASE_1     = 16'h4000;
  localparam logic [15:0] A16_BASE_2     = 16'h8000;
  localparam logic [15:0] A16_BASE_3     = 16'hC000;
  // option value forced in compatibility mode; recompile enable value loaded at reset
  localparam logic        COMPAT_FRO     = 1'b1;
  localparam logic        RECOMP_DEFAULT = 1'b0;
  // least reset pulse driven on the backplane, in ns, and in cycles
  localparam int          CLK_PERIOD_NS  = 5;
  localparam int          SYSRST_MIN_NS  = 200;
  localparam int          SYSRST_CYC     =
    (SYSRST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SYSRST_CNT_W   = 8;
  typedef enum logic [1:0] {
    ST_RUN,
    ST_FAULT,
    ST_DRIVE_RST,
    ST_WAIT_RST
  } fault_state_t;
endpackage : fault_reset_role_pkg

// *** src/cfg_bus_if.sv ***
// decoded configuration passed from the decoder to the recovery logic
interface cfg_bus_if;
  logic        compat_mode;
  logic        primary;
  logic        slot1;
  logic        fault_reset_option;
  logic        recompile_en;
  logic [23:0] a24_base;
  logic [15:0] a16_base;
  modport dec (output compat_mode, output primary, output slot1,
               output fault_reset_option, output recompile_en,
               output a24_base, output a16_base);
  modport use_cfg (input compat_mode, input primary, input slot1,
                   input fault_reset_option, input recompile_en,
                   input a24_base, input a16_base);
endinterface : cfg_bus_if

// *** src/switch_decoder.sv ***
// latches and decodes configuration switches on leaving reset
module switch_decoder
  import fault_reset_role_pkg::*;
(
  input  wire logic i_ref_clk,
  input  wire logic i_resetn,
  input  wire logic i_ce,
  input  wire logic i_base_addr_sel_hi,
  input  wire logic i_base_addr_sel_lo,
  input  wire logic i_fault_reset_option,
  input  wire logic i_config_source_sel,
  input  wire logic i_primary_role_sel,
  input  wire logic i_recompile_enable_switch,
  input  wire logic i_slot1,
  cfg_bus_if.dec    cfg
);
  logic        captured_reg;
  logic        compat_reg;
  logic        primary_reg;
  logic        slot1_reg;
  logic        fro_reg;
  logic        recomp_reg;
  logic [1:0]  sel_reg;
  logic        compat_next;
  logic [1:0]  sel_next;
  logic        primary_next;
  logic        fro_next;

  assign compat_next  = i_config_source_sel;
  assign sel_next     = compat_next ? SEL_ON_ON
                      : {i_base_addr_sel_hi, i_base_addr_sel_lo};
  assign fro_next     = compat_next ? COMPAT_FRO
                      : i_fault_reset_option;
  // compat ignores the role switch; only slot 1 can then be primary
  assign primary_next = i_slot1 |
                        (~compat_next & i_primary_role_sel);

  // capture once after reset release; a strap must not hit the reset path
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      captured_reg <= 1'b0;
      compat_reg   <= 1'b1;
      primary_reg  <= 1'b0;
      slot1_reg    <= 1'b0;
      fro_reg      <= COMPAT_FRO;
      recomp_reg   <= RECOMP_DEFAULT;
      sel_reg      <= SEL_ON_ON;
    end else if (i_ce && !captured_reg) begin
      captured_reg <= 1'b1;
      compat_reg   <= compat_next;
      primary_reg  <= primary_next;
      slot1_reg    <= i_slot1;
      fro_reg      <= fro_next;
      recomp_reg   <= i_recompile_enable_switch;
      sel_reg      <= sel_next;
    end
  end

  assign cfg.compat_mode        = compat_reg;
  assign cfg.primary            = primary_reg;
  assign cfg.slot1              = slot1_reg;
  assign cfg.fault_reset_option = fro_reg;
  assign cfg.recompile_en       = recomp_reg;
  assign cfg.a24_base = (sel_reg == SEL_ON_ON)  ? A24_BASE_0
                      : (sel_reg == SEL_ON_OFF) ? A24_BASE_1
                      : (sel_reg == SEL_OFF_ON) ? A24_BASE_2
                      : A24_BASE_3;
  assign cfg.a16_base = (sel_reg == SEL_ON_ON)  ? A16_BASE_0
                      : (sel_reg == SEL_ON_OFF) ? A16_BASE_1
                      : (sel_reg == SEL_OFF_ON) ? A16_BASE_2
                      : A16_BASE_3;
endmodule : switch_decoder

// *** tb/fault_reset_role_chk.sv ***
// assertions on the decoded configuration and fault recovery outputs
module fault_reset_role_chk (
  input wire logic        i_ref_clk,
  input wire logic        i_resetn,
  input wire logic        i_base_addr_sel_hi,
  input wire logic        i_base_addr_sel_lo,
  input wire logic        i_fault_reset_option,
  input wire logic        i_config_source_sel,
  input wire logic        i_primary_role_sel,
  input wire logic        i_recompile_enable_switch,
  input wire logic        i_slot1,
  input wire logic        i_sysreset_seen,
  input wire logic        o_compat_mode,
  input wire logic        o_primary,
  input wire logic        o_recompile_en,
  input wire logic [23:0] o_a24_base,
  input wire logic [15:0] o_a16_base,
  input wire logic        o_sysreset_oe,
  input wire logic        o_to_program,
  input wire logic        o_in_fault
);
  logic [1:0] n_reg;
  logic [6:0] c_reg;
  logic       v;
  logic       eff;
  assign v   = n_reg[1];
  assign eff = c_reg[3] | c_reg[4];
  // assumes the clock enable stays high, as the bench keeps it
  always_ff @(posedge i_ref_clk) begin
    n_reg <= !i_resetn ? 2'h0 : n_reg + {1'b0, n_reg != 2'h3};
    if (i_resetn && n_reg == 2'h0) begin
      c_reg <= {i_base_addr_sel_hi, i_base_addr_sel_lo, i_fault_reset_option,
                i_config_source_sel, i_primary_role_sel,
                i_recompile_enable_switch, i_slot1};
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  mode_sel_a: assert property (v |-> o_compat_mode == c_reg[3])
    else $error("compat mode wrong");
  compat_dflt_a: assert property (v && c_reg[3] |->
    {o_a24_base, o_a16_base} == 40'h0 && o_primary == c_reg[0])
    else $error("compat defaults wrong");
  user_role_a: assert property (v && !c_reg[3] |->
    o_primary == (c_reg[2] | c_reg[0])) else $error("role wrong");
  slot_primary_a: assert property (v && c_reg[0] |-> o_primary)
    else $error("slot card not primary");
  recomp_en_a: assert property (v |-> o_recompile_en == c_reg[1])
    else $error("recompile wrong");
  base_dec_a: assert property (v && !c_reg[3] |->
    o_a24_base == {~c_reg[6:5], 22'h0} && o_a16_base == {~c_reg[6:5], 14'h0})
    else $error("base wrong");
  cfg_hold_a: assert property (n_reg == 2'h3 |-> $stable({o_compat_mode,
    o_primary, o_recompile_en, o_a24_base, o_a16_base}))
    else $error("config moved");
  slot_only_a: assert property (o_sysreset_oe |-> v && c_reg[0])
    else $error("reset driven off slot");
  no_reset_a: assert property (v && !eff |-> !o_sysreset_oe)
    else $error("reset driven with option off");
  // the driver is entered one edge after the fault state, so oe trails
  drive_rst_a: assert property ($rose(o_in_fault) && eff && c_reg[0]
    |=> o_sysreset_oe) else $error("reset not driven");
  wait_rst_a: assert property (o_in_fault && eff && !c_reg[0] &&
    !i_sysreset_seen |=> o_in_fault) else $error("left fault early");
  cover property ($rose(o_sysreset_oe));
  cover property (o_to_program && !eff);
  cover property (o_to_program && eff && !c_reg[0]);
endmodule : fault_reset_role_chk
bind fault_reset_role_config fault_reset_role_chk u_chk (.*);

// *** tb/peer_cards.sv ***
// peer cards on the backplane: secondaries and the external reset source
module peer_cards (
  input  wire logic i_ref_clk,
  input  wire logic i_in_fault,
  input  wire logic i_sysreset_oe,
  output logic      o_sysreset_seen,
  output logic      o_peers_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int fault_cyc = 0;
  always @(posedge i_ref_clk) fault_cyc <= i_in_fault ? fault_cyc + 1 : 0;
  // peers are all secondaries, so no card but the one under test can be primary
  assign o_peers_ready = i_in_fault && fault_cyc >= 3;
  // pulled-up line reads released as not seen; late reset comes from outside
  assign o_sysreset_seen = i_sysreset_oe || fault_cyc >= 12;
endmodule : peer_cards

// *** tb/fault_reset_role_config_tb.sv ***
// self-checking bench for the switch decoder and fault recovery block
module fault_reset_role_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_ref_clk = 1'b0;
  logic        i_resetn  = 1'b0;
  logic        i_fault   = 1'b0;
  logic [6:0]  sw        = 7'h00;
  logic        seen, ready, oe_seen = 1'b0;
  logic        o_compat_mode, o_primary, o_recompile_en;
  logic        o_sysreset_oe, o_to_program, o_in_fault;
  logic [23:0] o_a24_base;
  logic [15:0] o_a16_base;
  logic [44:0] exp_q[$];
  logic [44:0] exp_v, got_v;
  int          errors = 0, comparisons = 0, cycles = 0, fcnt = 0;
  fault_reset_role_config #(.RST_CYC(2)) dut (
    .i_ref_clk, .i_resetn, .i_ce(1'b1), .i_base_addr_sel_hi(sw[6]),
    .i_base_addr_sel_lo(sw[5]), .i_fault_reset_option(sw[4]),
    .i_config_source_sel(sw[3]), .i_primary_role_sel(sw[2]),
    .i_recompile_enable_switch(sw[1]), .i_slot1(sw[0]), .i_fault,
    .i_sysreset_seen(seen), .i_peers_ready(ready), .o_compat_mode,
    .o_primary, .o_recompile_en, .o_a24_base, .o_a16_base,
    .o_sysreset_out(), .o_sysreset_oe, .o_to_program, .o_in_fault);
  peer_cards peers (.i_ref_clk, .i_in_fault(o_in_fault),
    .i_sysreset_oe(o_sysreset_oe), .o_sysreset_seen(seen),
    .o_peers_ready(ready));
  task automatic end_sim;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic check(input string nm, input logic [44:0] e, g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  // s = {hi, lo, option, source, role, recompile, slot}
  task automatic run_test(input logic [6:0] s);
    logic pri;
    logic [1:0] path;
    pri  = s[3] ? s[0] : (s[2] | s[0]);
    path = !(s[3] | s[4]) ? 2'h0 : (s[0] ? 2'h2 : 2'h1);
    i_resetn <= 1'b0;
    sw       <= s;
    repeat (2) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    @(posedge i_ref_clk);
    exp_q.push_back({s[3], pri, s[1], s[3] ? 24'h0 : {~s[6:5], 22'h0},
                     s[3] ? 16'h0 : {~s[6:5], 14'h0}, path});
    @(posedge i_ref_clk);
    // flipping every switch after capture must change nothing
    sw <= ~s;
    repeat (3) @(posedge i_ref_clk);
    i_fault <= 1'b1;
    @(posedge i_ref_clk);
    i_fault <= 1'b0;
    repeat (40) if (exp_q.size() != 0) @(posedge i_ref_clk);
    // a recovery that never returns leaves its note behind
    comparisons++;
    if (exp_q.size() != 0) begin
      errors++;
      $display("mismatch return expected %0d seen %0d", 0, exp_q.size());
      exp_q.delete();
    end
  endtask : run_test
  // path seen: 2 drove reset, 1 waited for outside reset, 0 coordinated
  always @(posedge i_ref_clk) begin
    if (o_in_fault) fcnt++;
    if (o_sysreset_oe) oe_seen = 1'b1;
    if (o_to_program && exp_q.size() != 0) begin
      exp_v = exp_q.pop_front();
      got_v = {o_compat_mode, o_primary, o_recompile_en, o_a24_base,
               o_a16_base, oe_seen ? 2'h2 : (fcnt > 8 ? 2'h1 : 2'h0)};
      check("config", exp_v[44:2], got_v[44:2]);
      check("recovery", exp_v[1:0], got_v[1:0]);
      fcnt = 0;
      oe_seen = 1'b0;
    end
    if (++cycles == 5000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    logic [6:0] fixed[5] = '{7'h09, 7'h11, 7'h14, 7'h46, 7'h28};
    void'($urandom(16598));
    repeat (10) @(posedge i_ref_clk);
    foreach (fixed[k]) run_test(fixed[k]);
    repeat (16) run_test(7'($urandom()));
    end_sim();
  end
endmodule : fault_reset_role_config_tb
